/* File: hdl/mode_seq_pkg.sv */
// Constants, frame layout and mode encoding for the operating-mode sequencer.
package mode_seq_pkg;

  // --------------------------------------------------------------------------
  // Clock and timing
  // --------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_DWELL_NS = 400;
  localparam int RESET_DWELL_CYCLES = (RESET_DWELL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_HOLD_US = 100;
  localparam int WAKE_HOLD_CYCLES = (WAKE_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_ENTRY_US = 1000;
  localparam int SLEEP_ENTRY_CYCLES =
    (SLEEP_ENTRY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RETRY_INTERVAL_US = 10000;
  localparam int RETRY_INTERVAL_CYCLES = (RETRY_INTERVAL_US * 1000) / CLK_PERIOD_NS;
  localparam int CNT_W = 24;

  // --------------------------------------------------------------------------
  // Serial frame layout
  // --------------------------------------------------------------------------
  localparam int FRAME_BITS = 32;
  localparam int BIT_CNT_W = 6;
  localparam int OP_MSB = 31;
  localparam int OP_LSB = 30;
  localparam int ADDR_MSB = 29;
  localparam int ADDR_LSB = 24;
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [5:0] ADDR_CONTROL_WORD_ONE = 6'h01;
  localparam logic [5:0] ADDR_CONTROL_WORD_TWO = 6'h02;
  localparam int MODE_KEY_BIT = 1;
  localparam int GO_ACTIVE_BIT = 2;
  localparam int SLEEP_REQUEST_BIT = 3;

  // --------------------------------------------------------------------------
  // Synchroniser reset values, ordered as the module packs its pins
  // --------------------------------------------------------------------------
  localparam logic [6:0] PIN_SYNC_RESET = 7'h02;

  // --------------------------------------------------------------------------
  // Operating modes
  // --------------------------------------------------------------------------
  typedef enum logic [4:0] {
    MODE_STANDBY = 5'h01,
    MODE_PRE_STANDBY = 5'h02,
    MODE_RESET = 5'h04,
    MODE_LIMP_HOME = 5'h08,
    MODE_ACTIVE = 5'h10
  } op_mode_t;

endpackage

/* File: hdl/operating_mode_sequencer.sv */
// Operating-mode state machine with pin wake/sleep timing and keyed serial mode changes.
//
// Function
// - After power-on reset the device sits in Standby with the serial port inactive.
// - Standby wakes when drive input high or chip select low exceeds wake hold time.
// - Leaving Standby always goes into Reset first.
// - Reset returns all control and status to defaults; serial traffic is ignored.
// - Reset ends by itself after about 400 ns, entering Limp home.
// - Limp home: direct input control, channel one follows drive input, channel two off.
// - Limp home accepts writes but only the key sequences change behaviour.
// - A serial mode change, except the Active go-zero sleep-zero reset, starts with a key frame; the selecting frame must follow next.
// - Limp home, key then sleep one and go zero heads towards Standby.
// - Limp home, key then sleep zero and go one enters Active, bucks running.
// - Key then go zero, sleep one enters Pre-standby: bucks off, port active.
// - Pre-standby drops to Standby after select high and input low past sleep time.
// - Active enters Reset on interface supply undervoltage or watchdog failure.
// - Active, a single frame with go zero and sleep zero forces Reset.
// - Active, key then go one and sleep one forces Reset.
// - Limp home clears the functional fault flag every retry interval.
// - Limp home restarts an over-temperature latched channel each retry once cooled.
module operating_mode_sequencer #(
  parameter int WAKE_HOLD_CYCLES = mode_seq_pkg::WAKE_HOLD_CYCLES,
  parameter int SLEEP_ENTRY_CYCLES = mode_seq_pkg::SLEEP_ENTRY_CYCLES,
  parameter int RETRY_INTERVAL_CYCLES = mode_seq_pkg::RETRY_INTERVAL_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic direct_drive_input,
  input wire logic chip_select_low,
  input wire logic spi_clock,
  input wire logic spi_data_in,
  input wire logic interface_supply_uv,
  input wire logic watchdog_fail,
  input wire logic fault_event,
  input wire logic fault_clear,
  input wire logic [1:0] ovt_event,
  input wire logic [1:0] ovt_clear,
  input wire logic [1:0] temp_released,
  output logic [4:0] op_mode,
  output logic spi_active,
  output logic regs_reset,
  output logic direct_input_enable,
  output logic buck1_enable,
  output logic buck2_enable,
  output logic functional_fault_flag,
  output logic [1:0] ovt_latched
);

  localparam int CW = mode_seq_pkg::CNT_W;
  localparam logic [CW-1:0] WAKE_LIM = CW'(WAKE_HOLD_CYCLES);
  localparam logic [CW-1:0] SLEEP_LIM = CW'(SLEEP_ENTRY_CYCLES);
  localparam logic [CW-1:0] RETRY_LIM = CW'(RETRY_INTERVAL_CYCLES - 1);
  localparam logic [CW-1:0] DWELL_LIM = CW'(mode_seq_pkg::RESET_DWELL_CYCLES - 1);
  localparam logic [mode_seq_pkg::BIT_CNT_W-1:0] FULL_FRAME =
    mode_seq_pkg::BIT_CNT_W'(mode_seq_pkg::FRAME_BITS);

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------

  // Counts while the qualifying level holds, saturates at the limit, and
  // drops to zero the moment the level breaks.
  function automatic logic [CW-1:0] hold_count(input logic cond, input logic [CW-1:0] cnt,
                                               input logic [CW-1:0] lim);
    logic [CW-1:0] res;
    res = '0;
    if (cond && (cnt < lim)) begin
      res = cnt + CW'(1);
    end else if (cond) begin
      res = cnt;
    end
    return res;
  endfunction

  function automatic logic is_write_to(input logic [31:0] frame, input logic [5:0] addr);
    return (frame[mode_seq_pkg::OP_MSB:mode_seq_pkg::OP_LSB] == mode_seq_pkg::OP_WRITE) &&
           (frame[mode_seq_pkg::ADDR_MSB:mode_seq_pkg::ADDR_LSB] == addr);
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [6:0] pin_meta_reg;
  logic [6:0] pin_sync_reg;
  logic sclk_prev_reg;
  logic csn_prev_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_meta_reg <= mode_seq_pkg::PIN_SYNC_RESET;
      pin_sync_reg <= mode_seq_pkg::PIN_SYNC_RESET;
    end else begin
      pin_meta_reg <= {temp_released, interface_supply_uv, spi_data_in, spi_clock,
                       chip_select_low, direct_drive_input};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  logic din_s;
  logic csn_s;
  logic sclk_s;
  logic mosi_s;
  logic uv_s;
  logic [1:0] cool_s;

  assign din_s = pin_sync_reg[0];
  assign csn_s = pin_sync_reg[1];
  assign sclk_s = pin_sync_reg[2];
  assign mosi_s = pin_sync_reg[3];
  assign uv_s = pin_sync_reg[4];
  assign cool_s = pin_sync_reg[6:5];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sclk_prev_reg <= 1'b0;
      csn_prev_reg <= 1'b1;
    end else begin
      sclk_prev_reg <= sclk_s;
      csn_prev_reg <= csn_s;
    end
  end

  // --------------------------------------------------------------------------
  // Mode register and frame receiver
  // --------------------------------------------------------------------------
  mode_seq_pkg::op_mode_t mode_reg;
  mode_seq_pkg::op_mode_t mode_next;
  logic [31:0] shift_reg;
  logic [mode_seq_pkg::BIT_CNT_W-1:0] bit_cnt_reg;
  logic sclk_rise;
  logic frame_end;
  logic frame_done;
  logic port_on;

  assign sclk_rise = sclk_s & ~sclk_prev_reg & ~csn_s;
  assign frame_end = csn_s & ~csn_prev_reg;
  assign port_on = (mode_reg == mode_seq_pkg::MODE_PRE_STANDBY) ||
                   (mode_reg == mode_seq_pkg::MODE_LIMP_HOME) ||
                   (mode_reg == mode_seq_pkg::MODE_ACTIVE);
  // A frame counts only when exactly a full word was clocked in; short or
  // long frames are dropped so that a glitch cannot fake a mode change.
  assign frame_done = frame_end && port_on && (bit_cnt_reg == FULL_FRAME);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shift_reg <= 32'h0000_0000;
      bit_cnt_reg <= '0;
    end else if (frame_end || !port_on) begin
      bit_cnt_reg <= '0;
    end else if (sclk_rise) begin
      shift_reg <= {shift_reg[30:0], mosi_s};
      if (bit_cnt_reg <= FULL_FRAME) begin
        bit_cnt_reg <= bit_cnt_reg + mode_seq_pkg::BIT_CNT_W'(1);
      end
    end
  end

  // --------------------------------------------------------------------------
  // Frame decode and key handling
  // --------------------------------------------------------------------------
  logic key_frame;
  logic select_frame;
  logic go_bit;
  logic sleep_bit;
  logic key_pending_reg;

  assign key_frame = frame_done &&
                     is_write_to(shift_reg, mode_seq_pkg::ADDR_CONTROL_WORD_ONE) &&
                     shift_reg[mode_seq_pkg::MODE_KEY_BIT];
  assign select_frame = frame_done &&
                        is_write_to(shift_reg, mode_seq_pkg::ADDR_CONTROL_WORD_TWO);
  assign go_bit = shift_reg[mode_seq_pkg::GO_ACTIVE_BIT];
  assign sleep_bit = shift_reg[mode_seq_pkg::SLEEP_REQUEST_BIT];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      key_pending_reg <= 1'b0;
    end else if (mode_next != mode_reg) begin
      key_pending_reg <= 1'b0;
    end else if (frame_done) begin
      key_pending_reg <= key_frame;
    end
  end

  // --------------------------------------------------------------------------
  // Timed pin conditions
  // --------------------------------------------------------------------------
  logic [CW-1:0] wake_cnt_reg;
  logic [CW-1:0] sleep_cnt_reg;
  logic [CW-1:0] dwell_cnt_reg;
  logic wake_cond;
  logic sleep_cond;
  logic wake_hit;
  logic sleep_hit;
  logic dwell_done;

  assign wake_cond = (mode_reg == mode_seq_pkg::MODE_STANDBY) && (din_s || !csn_s);
  assign sleep_cond = (mode_reg == mode_seq_pkg::MODE_PRE_STANDBY) && csn_s && !din_s;
  // Counting to the limit and then demanding one more cycle of the level
  // makes the hold strictly longer than the set time.
  assign wake_hit = wake_cond && (wake_cnt_reg == WAKE_LIM);
  assign sleep_hit = sleep_cond && (sleep_cnt_reg == SLEEP_LIM);
  assign dwell_done = (mode_reg == mode_seq_pkg::MODE_RESET) && (dwell_cnt_reg == DWELL_LIM);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wake_cnt_reg <= '0;
      sleep_cnt_reg <= '0;
    end else begin
      wake_cnt_reg <= hold_count(wake_cond, wake_cnt_reg, WAKE_LIM);
      sleep_cnt_reg <= hold_count(sleep_cond, sleep_cnt_reg, SLEEP_LIM);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dwell_cnt_reg <= '0;
    end else begin
      dwell_cnt_reg <= hold_count(mode_reg == mode_seq_pkg::MODE_RESET, dwell_cnt_reg,
                                  DWELL_LIM);
    end
  end

  // --------------------------------------------------------------------------
  // Mode transitions
  // --------------------------------------------------------------------------
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      mode_seq_pkg::MODE_STANDBY: begin
        if (wake_hit) begin
          mode_next = mode_seq_pkg::MODE_RESET;
        end
      end
      mode_seq_pkg::MODE_RESET: begin
        if (dwell_done) begin
          mode_next = mode_seq_pkg::MODE_LIMP_HOME;
        end
      end
      mode_seq_pkg::MODE_LIMP_HOME: begin
        if (key_pending_reg && select_frame && !go_bit && sleep_bit) begin
          mode_next = mode_seq_pkg::MODE_PRE_STANDBY;
        end else if (key_pending_reg && select_frame && go_bit && !sleep_bit) begin
          mode_next = mode_seq_pkg::MODE_ACTIVE;
        end
      end
      mode_seq_pkg::MODE_PRE_STANDBY: begin
        if (sleep_hit) begin
          mode_next = mode_seq_pkg::MODE_STANDBY;
        end
      end
      mode_seq_pkg::MODE_ACTIVE: begin
        if (uv_s || watchdog_fail) begin
          mode_next = mode_seq_pkg::MODE_RESET;
        end else if (select_frame && !go_bit && !sleep_bit) begin
          mode_next = mode_seq_pkg::MODE_RESET;
        end else if (key_pending_reg && select_frame && go_bit && sleep_bit) begin
          mode_next = mode_seq_pkg::MODE_RESET;
        end else if (key_pending_reg && select_frame && !go_bit && sleep_bit) begin
          mode_next = mode_seq_pkg::MODE_PRE_STANDBY;
        end
      end
      default: begin
        mode_next = mode_seq_pkg::MODE_RESET;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_reg <= mode_seq_pkg::MODE_STANDBY;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // --------------------------------------------------------------------------
  // Limp home retry timer and fault flags
  // --------------------------------------------------------------------------
  logic [CW-1:0] retry_cnt_reg;
  logic retry_tick;
  logic in_limp;
  logic in_reset;

  assign in_limp = (mode_reg == mode_seq_pkg::MODE_LIMP_HOME);
  assign in_reset = (mode_reg == mode_seq_pkg::MODE_RESET);
  assign retry_tick = in_limp && (retry_cnt_reg == RETRY_LIM);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      retry_cnt_reg <= '0;
    end else begin
      retry_cnt_reg <= hold_count(in_limp && !retry_tick, retry_cnt_reg, RETRY_LIM);
    end
  end

  // A fault reported in the same cycle as a clear keeps the flag set, so a
  // new fault is never swallowed by a periodic or software clear.
  // functional fault flag set and clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      functional_fault_flag <= 1'b0;
    end else if (fault_event) begin
      functional_fault_flag <= 1'b1;
    end else if (in_reset || retry_tick ||
                 (fault_clear && (mode_reg == mode_seq_pkg::MODE_ACTIVE))) begin
      functional_fault_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ovt_latched <= 2'h0;
    end else begin
      for (int ch = 0; ch < 2; ch++) begin
        if (ovt_event[ch]) begin
          ovt_latched[ch] <= 1'b1;
        end else if (in_reset) begin
          ovt_latched[ch] <= 1'b0;
        end else if (cool_s[ch] && (retry_tick ||
                     (ovt_clear[ch] && (mode_reg == mode_seq_pkg::MODE_ACTIVE)))) begin
          ovt_latched[ch] <= 1'b0;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Mode-dependent outputs
  // --------------------------------------------------------------------------
  // Mode, port, reset and direct-input outputs are registered from the next mode so they line up with mode_reg.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      op_mode <= mode_seq_pkg::MODE_STANDBY;
      spi_active <= 1'b0;
      regs_reset <= 1'b0;
      direct_input_enable <= 1'b0;
    end else begin
      op_mode <= mode_next;
      spi_active <= (mode_next == mode_seq_pkg::MODE_PRE_STANDBY) ||
                    (mode_next == mode_seq_pkg::MODE_LIMP_HOME) ||
                    (mode_next == mode_seq_pkg::MODE_ACTIVE);
      regs_reset <= (mode_next == mode_seq_pkg::MODE_RESET);
      direct_input_enable <= (mode_next == mode_seq_pkg::MODE_LIMP_HOME);
    end
  end

  // Channel mapping in Active is owned by the configuration logic; here the
  // channels are only permitted to run, and a thermal latch always wins.
  // limp home and active drive
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      buck1_enable <= 1'b0;
      buck2_enable <= 1'b0;
    end else if (mode_reg == mode_seq_pkg::MODE_LIMP_HOME) begin
      buck1_enable <= din_s && !ovt_latched[0];
      buck2_enable <= 1'b0;
    end else if (mode_reg == mode_seq_pkg::MODE_ACTIVE) begin
      buck1_enable <= !ovt_latched[0];
      buck2_enable <= !ovt_latched[1];
    end else begin
      buck1_enable <= 1'b0;
      buck2_enable <= 1'b0;
    end
  end

endmodule

/* File: test/host_model.sv */
// Host microcontroller model driving serial frames and the select pin.
module host_model (
  output logic chip_select_low,
  output logic spi_clock,
  output logic spi_data_in
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    chip_select_low = 1'b1;
    spi_clock = 1'b0;
    spi_data_in = 1'b0;
  end
  task automatic send_frame(input logic [31:0] word);
    chip_select_low = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      spi_data_in = word[i];
      #62.5 spi_clock = 1'b1;
      #62.5 spi_clock = 1'b0;
    end
    #62.5 chip_select_low = 1'b1;
    // The data line has no pull, so a released line must not keep the last bit.
    spi_data_in = ~spi_data_in;
    // The gap is kept well below the Reset dwell so a caller still sees Reset.
    #100;
  endtask
  task automatic hold_select(input int ns);
    chip_select_low = 1'b0;
    #(ns);
    chip_select_low = 1'b1;
    #500;
  endtask
endmodule

/* File: test/mode_seq_monitor.sv */
// Port-level assertions for the operating-mode sequencer.
module mode_seq_monitor #(
  parameter int RETRY_INTERVAL_CYCLES = 50
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic watchdog_fail,
  input wire logic [4:0] op_mode,
  input wire logic spi_active,
  input wire logic regs_reset,
  input wire logic direct_input_enable,
  input wire logic buck1_enable,
  input wire logic buck2_enable,
  input wire logic functional_fault_flag
);
  timeunit 1ns;
  timeprecision 100ps;
  logic in_std;
  logic in_pre;
  logic in_rst;
  logic in_limp;
  logic in_act;
  logic [5:0] dwell_reg;
  logic [31:0] hold_reg;
  assign in_std = op_mode == mode_seq_pkg::MODE_STANDBY;
  assign in_pre = op_mode == mode_seq_pkg::MODE_PRE_STANDBY;
  assign in_rst = op_mode == mode_seq_pkg::MODE_RESET;
  assign in_limp = op_mode == mode_seq_pkg::MODE_LIMP_HOME;
  assign in_act = op_mode == mode_seq_pkg::MODE_ACTIVE;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // Cycles spent in Reset and with the fault flag standing in Limp home.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dwell_reg <= 6'h00;
      hold_reg <= 32'h0;
    end else begin
      dwell_reg <= in_rst ? dwell_reg + 6'h01 : 6'h00;
      hold_reg <= (in_limp && functional_fault_flag) ? hold_reg + 32'h1 : 32'h0;
    end
  end
  reset_dwell_a: assert property (in_rst ##1 !in_rst |->
    in_limp && dwell_reg inside {[6'h27:6'h29]}) else $error("reset dwell wrong");
  standby_exit_a: assert property ($past(in_std) && !in_std |-> in_rst)
    else $error("standby left to wrong mode");
  port_active_a: assert property (spi_active == (in_pre || in_limp || in_act))
    else $error("serial port state wrong");
  regs_default_a: assert property (regs_reset == in_rst)
    else $error("register reset wrong");
  limp_direct_a: assert property (direct_input_enable == in_limp)
    else $error("direct input enable wrong");
  bucks_off_a: assert property (!$past(in_act) && !$past(in_limp) |->
    !buck1_enable && !buck2_enable) else $error("buck on outside run modes");
  limp_buck2_a: assert property ($past(in_limp) |-> !buck2_enable)
    else $error("channel two on in limp home");
  wd_reset_a: assert property (in_act && watchdog_fail |=> in_rst)
    else $error("watchdog failure did not reset");
  active_exit_a: assert property ($past(in_act) && !in_act |-> in_rst || in_pre)
    else $error("active left to wrong mode");
  limp_exit_a: assert property ($past(in_limp) && !in_limp |-> in_act || in_pre)
    else $error("limp home left to wrong mode");
  pre_exit_a: assert property ($past(in_pre) && !in_pre |-> in_std)
    else $error("pre-standby left to wrong mode");
  fault_retry_a: assert property (hold_reg <= 32'(RETRY_INTERVAL_CYCLES + 2))
    else $error("fault flag not retried");
endmodule

/* File: test/tb_top.sv */
// Self-checking bench for the operating-mode sequencer.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WAKE_N = 20;
  localparam int SLEEP_N = 30;
  localparam int RETRY_N = 50;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic din = 1'b0;
  logic uv = 1'b0;
  logic wd = 1'b0;
  logic f_ev = 1'b0;
  logic f_clr = 1'b0;
  logic [1:0] o_ev = 2'h0;
  logic [1:0] o_clr = 2'h0;
  logic [1:0] cool = 2'h3;
  logic cs_n;
  logic sck;
  logic sdi;
  logic [4:0] op_mode;
  logic spi_active;
  logic regs_reset;
  logic die;
  logic b1;
  logic b2;
  logic flag;
  logic [1:0] ovt;
  int err_total = 0;
  int n_checks = 0;
  int cycles = 0;
  always #5 clk_sys = ~clk_sys;
  host_model u_host (.chip_select_low(cs_n), .spi_clock(sck), .spi_data_in(sdi));
  operating_mode_sequencer #(.WAKE_HOLD_CYCLES(WAKE_N), .SLEEP_ENTRY_CYCLES(SLEEP_N),
    .RETRY_INTERVAL_CYCLES(RETRY_N)) u_dut (.clk_sys(clk_sys), .rst(rst),
    .direct_drive_input(din), .chip_select_low(cs_n), .spi_clock(sck), .spi_data_in(sdi),
    .interface_supply_uv(uv), .watchdog_fail(wd), .fault_event(f_ev), .fault_clear(f_clr),
    .ovt_event(o_ev), .ovt_clear(o_clr), .temp_released(cool), .op_mode(op_mode),
    .spi_active(spi_active), .regs_reset(regs_reset), .direct_input_enable(die),
    .buck1_enable(b1), .buck2_enable(b2), .functional_fault_flag(flag), .ovt_latched(ovt));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_mode(input logic [4:0] m);
    for (int i = 0; i < 400 && op_mode !== m; i++) tick(1);
    check(op_mode, m);
  endtask
  task automatic sel(input logic go, input logic sleep);
    u_host.send_frame(32'h0100_0002);
    u_host.send_frame({28'h020_0000, sleep, go, 2'h0});
  endtask
  task automatic go_active();
    sel(1'b1, 1'b0);
    wait_mode(mode_seq_pkg::MODE_ACTIVE);
  endtask
  task automatic back_to_limp();
    wait_mode(mode_seq_pkg::MODE_RESET);
    wait_mode(mode_seq_pkg::MODE_LIMP_HOME);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      $display("[FAIL] %0t run too long", $time);
      finish_test();
    end
  end
  initial begin
    int n;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    tick(1);
    check({op_mode, spi_active}, {mode_seq_pkg::MODE_STANDBY, 1'b0});
    @(posedge clk_sys) din <= 1'b1;
    tick(15);
    @(posedge clk_sys) din <= 1'b0;
    tick(3);
    @(posedge clk_sys) din <= 1'b1;
    tick(15);
    check(op_mode, mode_seq_pkg::MODE_STANDBY);
    wait_mode(mode_seq_pkg::MODE_RESET);
    check(regs_reset, 1'b1);
    for (n = 0; n < 60 && op_mode === mode_seq_pkg::MODE_RESET; n++) tick(1);
    check(n inside {[39:41]}, 1'b1);
    check(op_mode, mode_seq_pkg::MODE_LIMP_HOME);
    tick(2);
    check({b1, b2}, 2'h2);
    check(die, 1'b1);
    @(posedge clk_sys) din <= 1'b0;
    tick(5);
    check(b1, 1'b0);
    u_host.send_frame(32'h0200_0004);
    sel(1'b1, 1'b1);
    u_host.send_frame(32'h0100_0002);
    u_host.send_frame(32'h0100_0000);
    u_host.send_frame(32'h0200_0004);
    check(op_mode, mode_seq_pkg::MODE_LIMP_HOME);
    @(posedge clk_sys) begin
      f_ev <= 1'b1;
      o_ev <= 2'h1;
    end
    @(posedge clk_sys) begin
      f_ev <= 1'b0;
      o_ev <= 2'h0;
    end
    #1 check({flag, ovt}, 3'h5);
    tick(RETRY_N + 5);
    check({flag, ovt}, 3'h0);
    // A hot channel must stay latched through retries until it has cooled.
    @(posedge clk_sys) cool <= 2'h2;
    tick(3);
    @(posedge clk_sys) o_ev <= 2'h1;
    @(posedge clk_sys) o_ev <= 2'h0;
    tick(RETRY_N + 5);
    check(ovt, 2'h1);
    @(posedge clk_sys) cool <= 2'h3;
    tick(RETRY_N + 5);
    check(ovt, 2'h0);
    go_active();
    tick(2);
    check({b1, b2}, 2'h3);
    @(posedge clk_sys) begin
      f_ev <= 1'b1;
      o_ev <= 2'h2;
    end
    @(posedge clk_sys) begin
      f_ev <= 1'b0;
      o_ev <= 2'h0;
      f_clr <= 1'b1;
      o_clr <= 2'h2;
    end
    @(posedge clk_sys) begin
      f_clr <= 1'b0;
      o_clr <= 2'h0;
    end
    tick(4);
    check({b2, flag, ovt}, 4'h8);
    u_host.send_frame(32'h0200_0000);
    back_to_limp();
    go_active();
    @(posedge clk_sys) wd <= 1'b1;
    @(posedge clk_sys) wd <= 1'b0;
    back_to_limp();
    go_active();
    @(posedge clk_sys) uv <= 1'b1;
    wait_mode(mode_seq_pkg::MODE_RESET);
    @(posedge clk_sys) uv <= 1'b0;
    wait_mode(mode_seq_pkg::MODE_LIMP_HOME);
    go_active();
    sel(1'b1, 1'b1);
    back_to_limp();
    go_active();
    @(posedge clk_sys) din <= 1'b1;
    sel(1'b0, 1'b1);
    wait_mode(mode_seq_pkg::MODE_PRE_STANDBY);
    tick(2);
    check({spi_active, b1, b2}, 3'h4);
    @(posedge clk_sys) din <= 1'b0;
    tick(SLEEP_N - 5);
    check(op_mode, mode_seq_pkg::MODE_PRE_STANDBY);
    wait_mode(mode_seq_pkg::MODE_STANDBY);
    u_host.hold_select(1000);
    wait_mode(mode_seq_pkg::MODE_LIMP_HOME);
    @(posedge clk_sys) din <= 1'b1;
    sel(1'b0, 1'b1);
    wait_mode(mode_seq_pkg::MODE_PRE_STANDBY);
    @(posedge clk_sys) din <= 1'b0;
    wait_mode(mode_seq_pkg::MODE_STANDBY);
    finish_test();
  end
endmodule

bind operating_mode_sequencer mode_seq_monitor #(
  .RETRY_INTERVAL_CYCLES(RETRY_INTERVAL_CYCLES)
) u_mon (
  .clk_sys(clk_sys),
  .rst(rst),
  .watchdog_fail(watchdog_fail),
  .op_mode(op_mode),
  .spi_active(spi_active),
  .regs_reset(regs_reset),
  .direct_input_enable(direct_input_enable),
  .buck1_enable(buck1_enable),
  .buck2_enable(buck2_enable),
  .functional_fault_flag(functional_fault_flag)
);
